// ===== inc/dadma_map.svh
`ifndef DADMA_MAP_SVH
`define DADMA_MAP_SVH
// Behaviour
// R01: Source read drives source pointer, source code, size; data held on ack.
// R02: After whole source operand, source pointer steps by one, two or four.
// R03: Write holding data to destination; then step pointer, reduce count.
// R04: Two to four cycles per operand; 8-bit bus is one read, one write.
// R05: 16-bit equal sizes: no packing; odd word splits into two byte cycles.
// R06: Unequal sizes pack or unpack; byte side takes two cycles.
// R07: Steps: 8-bit +1/+1; 16-bit bb +1/+1, bw +4/+2, wb +2/+4, ww +2/+2.
// R08: 16-bit cycle patterns per size and alignment; 8-bit others count twice.
// R09: Half-bus 8-bit peripheral set to word size packs, address steps four.
// R10: Internal requests start on start bit; external only while it is set.
// R11: Maximum rate runs back to back; yields on bus clear or interrupt.
// R12: Limited rate caps use to 12.5/25/50/75 percent of 1024 clocks.
// R13: Burst: peripheral holds request; ack asserted on each device access.
// R14: Burst: request held at sampling point starts next operand, else release.
// R15: Byte-to-word packing samples request only in final byte cycle.
// R16: Cycle steal: falling edges; early edges ignored; late edge served.
// R17: Count one or two at operand start drives end in final device cycle.
// R18: Count reaching zero stops, clears start, steps pointers, interrupts.
// R19: Start with count zero moves 65536 bytes.
// R20: End input at device sampling point finishes operand, then terminates.
// R21: Bus error aborts, clears start, flags source or destination error.
// R22: Clearing start halts the channel in any request mode.
// R23: Status flags set on event, write one clears, reset clears.
// R24: End during first byte of packed device access: finish, set flag.
// R25: After any termination go idle and release the bus.

// Register byte offsets
`define DADMA_OFF_MODE 8'h00
`define DADMA_OFF_SRC 8'h04
`define DADMA_OFF_DST 8'h08
`define DADMA_OFF_FC 8'h0c
`define DADMA_OFF_CNT 8'h10
`define DADMA_OFF_STAT 8'h14
`define DADMA_OFF_HOLD 8'h18

// Mode register fields
`define DADMA_M_START 0
`define DADMA_M_REQ_GEN_SEL 2:1
`define DADMA_M_BWSEL 4:3
`define DADMA_M_BUS_CLEAR_MODE 5
`define DADMA_M_ECO 6
`define DADMA_M_NORMAL_INT_EN 7
`define DADMA_M_ERROR_INT_EN 8
`define DADMA_M_SRC_SIZE 9
`define DADMA_M_DST_SIZE 10
`define DADMA_M_SINC 11
`define DADMA_M_DINC 12
`define DADMA_M_PDST 13
`define DADMA_M_BUS16 14
`define DADMA_MODE_RST 15'h0000

// Status register fields
`define DADMA_S_DONE 0
`define DADMA_S_BED 1
`define DADMA_S_BES 2
`define DADMA_S_DNS 3
`define DADMA_STAT_RST 4'h0

// Bandwidth window and limits
`define DADMA_WIN_BITS 10
`define DADMA_LIM_12 10'h080
`define DADMA_LIM_25 10'h100
`define DADMA_LIM_50 10'h200
`define DADMA_LIM_75 10'h300

`endif

// ===== inc/dadma_pkg.sv
package dadma_pkg;

  localparam int DADMA_AW = 24;
  localparam int DADMA_CW = 16;

  typedef enum logic [2:0] {
    st_idle = 3'b000,
    st_arb = 3'b001,
    st_read = 3'b010,
    st_write = 3'b011,
    st_next = 3'b100
  } dadma_state_type;

  typedef enum logic [1:0] {
    req_gen_sel_max = 2'b00,
    req_gen_sel_limit = 2'b01,
    req_gen_sel_burst = 2'b10,
    req_gen_sel_steal = 2'b11
  } dadma_req_gen_sel_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [2:0] fc;
    logic [DADMA_AW-1:0] addr;
    logic [15:0] wdata;
  } dadma_cyc_type;

endpackage : dadma_pkg

// ===== hw/dadma_top.sv
// Decided for this implementation: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "dadma_map.svh"

module dadma_top
  import dadma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic bus_req,
  input wire logic bus_grant,
  input wire logic bus_clear,
  input wire logic int_pending,
  output dadma_cyc_type cyc,
  input wire logic [15:0] m_rdata,
  input wire logic m_ack,
  input wire logic m_berr,
  input wire logic xfer_request_b,
  output logic xfer_ack_b,
  input wire logic xfer_end_b_i,
  output logic xfer_end_b_o,
  output logic xfer_end_oe,
  output logic irq_normal,
  output logic irq_error
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [2:0] dadma_step(input logic b16,
                                            input logic own_w,
                                            input logic oth_w);
    dadma_step = !b16 ? 3'h1 : own_w ? 3'h2 : oth_w ? 3'h4 : 3'h1;
  endfunction : dadma_step

  function automatic logic dadma_two(input logic b16, input logic own_w,
                                     input logic oth_w, input logic a0);
    dadma_two = b16 & (own_w ? a0 : oth_w);
  endfunction : dadma_two

  function automatic logic [7:0] dadma_lane(input logic [15:0] d,
                                            input logic odd);
    dadma_lane = odd ? d[7:0] : d[15:8];
  endfunction : dadma_lane

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [14:0] mode_q, mode_d;
  logic [DADMA_AW-1:0] src_q, src_d, dst_q, dst_d;
  logic [7:0] fc_q, fc_d;
  logic [DADMA_CW-1:0] cnt_q, cnt_d;
  logic [3:0] stat_q, stat_d;
  logic [15:0] hold_q, hold_d;
  dadma_state_type state_q, state_d;
  logic k_q, k_d;
  logic [`DADMA_WIN_BITS-1:0] win_q;
  logic req_prev_q, steal_pend_q, ack_seen_q, burst_cont_q, end_seen_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  dadma_cyc_type cyc_d;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire start = mode_q[`DADMA_M_START];
  wire dadma_req_gen_sel_type req_gen_sel = dadma_req_gen_sel_type'(mode_q[`DADMA_M_REQ_GEN_SEL]);
  wire [1:0] bwsel = mode_q[`DADMA_M_BWSEL];
  wire bus16 = mode_q[`DADMA_M_BUS16];
  wire ssz = mode_q[`DADMA_M_SRC_SIZE];
  wire dsz = mode_q[`DADMA_M_DST_SIZE];
  wire ext = req_gen_sel[1];
  wire dev_is_dst = ext ? mode_q[`DADMA_M_PDST] : mode_q[`DADMA_M_ECO];
  wire busy = (state_q != st_idle);

  // ----------------------------------------------------------------
  // Operand plan, held stable because busy blocks setup writes
  // ----------------------------------------------------------------
  wire src_two = dadma_two(bus16, ssz, dsz, src_q[0]); // R05 R06 R08
  wire dst_two = dadma_two(bus16, dsz, ssz, dst_q[0]); // R05 R06 R08
  wire src_wide = bus16 & ssz & !src_q[0]; // R04 R05
  wire dst_wide = bus16 & dsz & !dst_q[0]; // R04 R05
  wire [2:0] src_step = dadma_step(bus16, ssz, dsz); // R07 R09
  wire [2:0] dst_step = dadma_step(bus16, dsz, ssz); // R07 R09
  wire op2 = bus16 & (ssz | dsz);
  wire end_due = (cnt_q == 16'h0001) | (op2 & (cnt_q == 16'h0002)); // R17

  wire in_cyc = (state_q == st_read) | (state_q == st_write);
  wire cur_wr = (state_q == st_write);
  wire cur_two = cur_wr ? dst_two : src_two;
  wire cur_wide = cur_wr ? dst_wide : src_wide;
  wire cur_str2 = bus16 & !(cur_wr ? dsz : ssz);
  wire [DADMA_AW-1:0] cur_base = cur_wr ? dst_q : src_q;
  // Packed byte side sits on one half of the bus, so stride two
  wire [DADMA_AW-1:0] cur_off = k_q ?
    (cur_str2 ? 24'h000002 : 24'h000001) : 24'h000000; // R09
  wire last = !cur_two | k_q;
  wire dev_cyc = (cur_wr == dev_is_dst);

  wire acked = cyc.valid & m_ack;
  wire errd = cyc.valid & m_berr;
  wire cyc_live = in_cyc & !acked & !errd;

  // ----------------------------------------------------------------
  // Request generation
  // ----------------------------------------------------------------
  wire req_now = !xfer_request_b;
  wire req_fall = req_now & !req_prev_q;
  wire [`DADMA_WIN_BITS-1:0] limit =
    (bwsel == 2'h0) ? `DADMA_LIM_12 :
    (bwsel == 2'h1) ? `DADMA_LIM_25 :
    (bwsel == 2'h2) ? `DADMA_LIM_50 : `DADMA_LIM_75;
  wire in_window = (win_q < limit); // R12
  // Bus clear only affects internally paced transfers
  wire yield = !ext & (bus_clear |
    (int_pending & mode_q[`DADMA_M_BUS_CLEAR_MODE])); // R11
  wire want_idle =
    (req_gen_sel == req_gen_sel_max) ? 1'b1 :
    (req_gen_sel == req_gen_sel_limit) ? in_window :
    (req_gen_sel == req_gen_sel_burst) ? req_now : steal_pend_q; // R10 R13 R16
  wire want_next =
    (req_gen_sel == req_gen_sel_max) ? 1'b1 :
    (req_gen_sel == req_gen_sel_limit) ? in_window :
    (req_gen_sel == req_gen_sel_burst) ? burst_cont_q : steal_pend_q; // R14 R16
  // Late edges count only once the current request was acknowledged
  wire steal_ok = !in_cyc | ack_seen_q; // R16

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  wire end_in = !xfer_end_b_i & !xfer_end_oe;
  wire dev_ack = acked & dev_cyc;
  wire op_done = acked & cur_wr & last;
  wire [DADMA_CW-1:0] cnt_sub =
    (op2 & (cnt_q != 16'h0001)) ? 16'h0002 : 16'h0001;
  wire [DADMA_CW-1:0] cnt_dec = cnt_q - cnt_sub; // R03 R19
  wire fin = (cnt_q == 16'h0000) | end_seen_q; // R18 R20
  wire go_idle = start & want_idle & !yield; // R10
  wire go_next = start & want_next & !yield; // R11 R22
  wire load = ((state_q == st_arb) & start & bus_grant) |
              ((state_q == st_next) & !fin & go_next);
  wire norm_end = (state_q == st_next) & fin;
  wire err_end = errd;
  wire [7:0] rd_lane = dadma_lane(m_rdata, cyc.addr[0]);

  always_comb begin
    state_d = state_q;
    k_d = k_q;
    unique case (state_q)
      st_idle: begin
        if (go_idle) begin
          state_d = st_arb;
        end
      end
      st_arb: begin
        if (!start) begin
          state_d = st_idle; // R22
        end else if (bus_grant) begin
          state_d = st_read;
          k_d = 1'b0;
        end
      end
      st_read, st_write: begin
        if (errd) begin
          state_d = st_idle; // R21 R25
          k_d = 1'b0;
        end else if (acked & last) begin
          state_d = cur_wr ? st_next : st_write;
          k_d = 1'b0;
        end else if (acked) begin
          k_d = 1'b1;
        end
      end
      st_next: begin
        state_d = load ? st_read : st_idle; // R14 R25
        k_d = 1'b0;
      end
      default: begin
        state_d = st_idle;
        k_d = 1'b0;
      end
    endcase
  end

  // Holding register capture
  always_comb begin
    hold_d = hold_q;
    if (acked & !cur_wr) begin
      if (cur_wide) begin
        hold_d = m_rdata; // R01
      end else if (cur_two) begin
        hold_d = k_q ? {hold_q[15:8], rd_lane} : {rd_lane, hold_q[7:0]}; // R06
      end else begin
        hold_d = {rd_lane, rd_lane}; // R01
      end
    end
  end

  // Bus cycle, one idle clock between cycles of an operand, two before the next operand
  always_comb begin
    cyc_d.valid = cyc_live;
    cyc_d.write = cur_wr;
    cyc_d.word = cur_wide;
    cyc_d.fc = cur_wr ? fc_q[6:4] : fc_q[2:0]; // R01 R03
    cyc_d.addr = cur_base + cur_off; // R01 R03
    if (cur_wide) begin
      cyc_d.wdata = hold_q; // R03
    end else if (cur_two & !k_q) begin
      cyc_d.wdata = {hold_q[15:8], hold_q[15:8]}; // R06
    end else begin
      cyc_d.wdata = {hold_q[7:0], hold_q[7:0]}; // R06
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  wire ah_sel = hsel & htrans[1] & hready;
  wire we_mode = wr_pend_q & (wr_addr_q == `DADMA_OFF_MODE);
  wire we_src = wr_pend_q & (wr_addr_q == `DADMA_OFF_SRC);
  wire we_dst = wr_pend_q & (wr_addr_q == `DADMA_OFF_DST);
  wire we_fc = wr_pend_q & (wr_addr_q == `DADMA_OFF_FC);
  wire we_cnt = wr_pend_q & (wr_addr_q == `DADMA_OFF_CNT);
  wire we_stat = wr_pend_q & (wr_addr_q == `DADMA_OFF_STAT);
  // Setup is frozen while running so the plan cannot shift mid-operand
  wire setup_ok = !busy & !start;
  wire [7:0] ra = haddr[7:0];
  wire [31:0] rd_mux =
    (ra == `DADMA_OFF_MODE) ? {17'h00000, mode_q} :
    (ra == `DADMA_OFF_SRC) ? {8'h00, src_q} :
    (ra == `DADMA_OFF_DST) ? {8'h00, dst_q} :
    (ra == `DADMA_OFF_FC) ? {24'h000000, fc_q} :
    (ra == `DADMA_OFF_CNT) ? {16'h0000, cnt_q} :
    (ra == `DADMA_OFF_STAT) ? {28'h0000000, stat_q} :
    (ra == `DADMA_OFF_HOLD) ? {16'h0000, hold_q} : 32'h00000000;

  always_comb begin
    mode_d = mode_q;
    if (we_mode) begin
      mode_d = busy ? {mode_q[14:1], hwdata[0]} : hwdata[14:0]; // R22
    end
    if (norm_end | err_end) begin
      mode_d[`DADMA_M_START] = 1'b0; // R18 R20 R21
    end
  end

  always_comb begin
    src_d = src_q;
    dst_d = dst_q;
    cnt_d = cnt_q;
    fc_d = fc_q;
    if (we_src & setup_ok) begin
      src_d = hwdata[DADMA_AW-1:0];
    end
    if (we_dst & setup_ok) begin
      dst_d = hwdata[DADMA_AW-1:0];
    end
    if (we_cnt & setup_ok) begin
      cnt_d = hwdata[DADMA_CW-1:0];
    end
    if (we_fc & setup_ok) begin
      fc_d = hwdata[7:0];
    end
    if (op_done) begin
      if (mode_q[`DADMA_M_SINC]) begin
        src_d = src_q + {21'h000000, src_step}; // R02 R07
      end
      if (mode_q[`DADMA_M_DINC]) begin
        dst_d = dst_q + {21'h000000, dst_step}; // R03 R07
      end
      cnt_d = cnt_dec; // R03
    end
  end

  // Set wins over a same-cycle write-one clear
  wire [3:0] stat_set = {
    dev_ack & end_in & cur_two & !k_q, // R24
    errd & !cur_wr, // R21
    errd & cur_wr, // R21
    norm_end}; // R18 R20
  wire [3:0] stat_clr = we_stat ? hwdata[3:0] : 4'h0;
  assign stat_d = (stat_q & ~stat_clr) | stat_set; // R23

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= `DADMA_MODE_RST;
      src_q <= 24'h000000;
      dst_q <= 24'h000000;
      fc_q <= 8'h00;
      cnt_q <= 16'h0000;
      stat_q <= `DADMA_STAT_RST;
      hold_q <= 16'h0000;
      state_q <= st_idle;
      k_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      src_q <= src_d;
      dst_q <= dst_d;
      fc_q <= fc_d;
      cnt_q <= cnt_d;
      stat_q <= stat_d;
      hold_q <= hold_d;
      state_q <= state_d;
      k_q <= k_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      win_q <= 10'h000;
      req_prev_q <= 1'b0;
      steal_pend_q <= 1'b0;
      ack_seen_q <= 1'b0;
      burst_cont_q <= 1'b0;
      end_seen_q <= 1'b0;
    end else begin
      win_q <= win_q + 10'h001; // R12
      req_prev_q <= req_now;
      steal_pend_q <= (steal_pend_q & !load) | (req_fall & steal_ok); // R16
      ack_seen_q <= (ack_seen_q & !load) | !xfer_ack_b; // R16
      if (dev_ack & last) begin
        burst_cont_q <= req_now; // R14 R15
      end
      if (load) begin
        end_seen_q <= 1'b0;
      end else if (dev_ack & end_in) begin
        end_seen_q <= 1'b1; // R20
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc <= '0;
      bus_req <= 1'b0;
      xfer_ack_b <= 1'b1;
      xfer_end_b_o <= 1'b1;
      xfer_end_oe <= 1'b0;
      irq_normal <= 1'b0;
      irq_error <= 1'b0;
    end else begin
      cyc <= cyc_d;
      bus_req <= (state_d != st_idle); // R25
      xfer_ack_b <= !(cyc_live & ext & dev_cyc); // R13
      xfer_end_b_o <= !(cyc_live & dev_cyc & last & end_due); // R17
      xfer_end_oe <= cyc_live & dev_cyc & last & end_due; // R17
      irq_normal <= stat_q[`DADMA_S_DONE] & mode_q[`DADMA_M_NORMAL_INT_EN]; // R18
      irq_error <= (stat_q[`DADMA_S_BED] | stat_q[`DADMA_S_BES]) &
                   mode_q[`DADMA_M_ERROR_INT_EN]; // R21
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= ah_sel & hwrite;
      wr_addr_q <= haddr[7:0];
      hrdata <= (ah_sel & !hwrite) ? rd_mux : 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking dadma_cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_ERR_STOPS: assert property (errd |=> !start && state_q == st_idle) // R21
    else $error("bus error did not stop channel");
  AST_ERR_FLAG: assert property (errd && !cur_wr |=> // R21
    stat_q[`DADMA_S_BES] &&
    (!stat_q[`DADMA_S_BED] || $past(stat_q[`DADMA_S_BED])))
    else $error("source bus error not flagged");
  AST_RELEASE: assert property (norm_end |=> !bus_req ##1 !cyc.valid) // R25
    else $error("bus kept after termination");
  AST_ACK_EXT: assert property (!xfer_ack_b |-> ext && cyc.valid) // R13
    else $error("ack outside external device cycle");
  AST_CNT_DEC: assert property (op_done |=> // R03
    $past(cnt_q) - cnt_q ==
    ($past(op2 && cnt_q != 16'h0001) ? 16'h0002 : 16'h0001))
    else $error("count not reduced by operand bytes");
  AST_ZERO_TERM: assert property (state_q == st_next // R18
    && cnt_q == 16'h0000 |=> !start && stat_q[`DADMA_S_DONE])
    else $error("zero count did not terminate");
  AST_BYTE_BUS: assert property (cyc.valid && !bus16 |-> !cyc.word) // R04
    else $error("word cycle on byte bus");
  AST_HALT: assert property (state_q == st_next && !start // R22
    |=> state_q == st_idle ##1 !bus_req)
    else $error("halt not honoured");
  AST_LIMIT: assert property (state_q == st_idle && req_gen_sel == req_gen_sel_limit // R12
    && !in_window |=> state_q == st_idle)
    else $error("limited rate ran outside window");
  AST_END_LAST: assert property (xfer_end_oe |-> // R17
    cyc.valid && $past(end_due))
    else $error("end driven outside final operand");
  AST_NO_IDLE_REQ: assert property (state_q == st_idle && !start // R10
    |=> !bus_req)
    else $error("bus requested while stopped");

  COV_MAX_RUN: cover property (req_gen_sel == req_gen_sel_max && norm_end);
  COV_PACK: cover property (op_done && bus16 && !ssz && dsz);
  COV_STEAL: cover property (req_gen_sel == req_gen_sel_steal && req_fall && steal_ok);
  COV_ERR: cover property (errd && cur_wr);

endmodule : dadma_top

// ===== testbench/dadma_partner.sv
`timescale 1ns/1ps

module dadma_partner
  import dadma_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire dadma_cyc_type cyc,
  output logic [15:0] m_rdata,
  output logic m_ack,
  output logic m_berr,
  output logic xfer_request_b,
  input wire logic xfer_ack_b,
  input wire logic xfer_end_b_o,
  input wire logic xfer_end_oe,
  output logic xfer_end_b_i,
  input wire logic slow,
  input wire logic [7:0] err_addr,
  input wire logic burst_req,
  input wire logic pulse_en,
  input wire logic end_first,
  output logic [7:0] ack_falls,
  output logic [7:0] end_cnt
);
  // ----------------------------------------
  // Memory and peripheral on the far side
  // ----------------------------------------
  logic [7:0] mem [0:255];
  logic [1:0] wait_q;
  logic [4:0] tick_q;
  logic ack_d_q;
  logic end_d_q;
  wire [7:0] a = cyc.addr[7:0];
  wire [7:0] ae = {a[7:1], 1'b0};
  wire end_drv = xfer_end_oe & !xfer_end_b_o;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
  end

  assign xfer_request_b = !(burst_req | (pulse_en & (tick_q == 5'h00)));
  // Open-drain end line with pull-up; first device access ends the block
  assign xfer_end_b_i = !(end_drv | (end_first & !xfer_ack_b));

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      m_ack <= 1'b0;
      m_berr <= 1'b0;
      m_rdata <= 16'h0000;
      wait_q <= 2'h0;
      tick_q <= 5'h00;
      ack_d_q <= 1'b1;
      end_d_q <= 1'b0;
      ack_falls <= 8'h00;
      end_cnt <= 8'h00;
    end else begin
      tick_q <= tick_q + 5'h01;
      ack_d_q <= xfer_ack_b;
      end_d_q <= end_drv;
      m_ack <= 1'b0;
      m_berr <= 1'b0;
      // Idle lines toggle so stale data never looks valid
      m_rdata <= ~m_rdata;
      if (ack_d_q & !xfer_ack_b) begin
        ack_falls <= ack_falls + 8'h01;
      end
      if (end_drv & !end_d_q) begin
        end_cnt <= end_cnt + 8'h01;
      end
      if (cyc.valid & !m_ack & !m_berr) begin
        if (slow & (wait_q != 2'h3)) begin
          wait_q <= wait_q + 2'h1;
        end else begin
          wait_q <= 2'h0;
          if (!cyc.write & (a == err_addr)) begin
            m_berr <= 1'b1;
          end else begin
            m_ack <= 1'b1;
            if (!cyc.write) begin
              m_rdata <= {mem[ae], mem[ae | 8'h01]};
            end else if (cyc.word) begin
              mem[ae] <= cyc.wdata[15:8];
              mem[ae | 8'h01] <= cyc.wdata[7:0];
            end else begin
              mem[a] <= a[0] ? cyc.wdata[7:0] : cyc.wdata[15:8];
            end
          end
        end
      end
    end
  end
endmodule : dadma_partner

// ===== testbench/dadma_top_test.sv
`timescale 1ns/1ps
`include "dadma_map.svh"

module dadma_top_test;
  import dadma_pkg::*;
  logic clk, rst_b, hsel, hwrite, bus_grant, slow, burst_req, pulse_en;
  logic end_first, bus_clear;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] err_addr, ack_falls, end_cnt, af0, ec0;
  wire hready, hreadyout, hresp, bus_req, m_ack, m_berr, xfer_request_b;
  wire xfer_ack_b, xfer_end_b_i, xfer_end_b_o, xfer_end_oe;
  wire irq_normal, irq_error;
  wire [15:0] m_rdata;
  dadma_cyc_type cyc;
  int mismatches, n_tests;
  logic [31:0] t_md [8] = '{32'h5f81, 32'h5d81, 32'h5b81, 32'h5981,
    32'h1981, 32'h5f83, 32'h7f85, 32'h7f87};
  logic [7:0] t_s [8] = '{8'h10, 8'h20, 8'h30, 8'h38, 8'h3c, 8'h00,
    8'h08, 8'h0c};
  logic [7:0] t_d [8] = '{8'h40, 8'h60, 8'h80, 8'h90, 8'ha0, 8'hb0,
    8'hc0, 8'hd0};
  logic [7:0] t_c [8] = '{8'h04, 8'h04, 8'h04, 8'h03, 8'h03, 8'h04,
    8'h04, 8'h04};
  logic [7:0] t_ss [8] = '{8'h04, 8'h08, 8'h04, 8'h03, 8'h03, 8'h04,
    8'h04, 8'h04};
  logic [7:0] t_ds [8] = '{8'h04, 8'h04, 8'h08, 8'h03, 8'h03, 8'h04,
    8'h04, 8'h04};
  int t_k [8] = '{0, 1, 2, 0, 0, 0, 0, 0};

  assign hready = hreadyout;
  always #25 clk = ~clk;
  always @(posedge clk) bus_grant <= bus_req;

  dadma_top dadma_top_inst (.clk(clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bus_req(bus_req),
    .bus_grant(bus_grant), .bus_clear(bus_clear), .int_pending(1'b0),
    .cyc(cyc), .m_rdata(m_rdata), .m_ack(m_ack), .m_berr(m_berr),
    .xfer_request_b(xfer_request_b), .xfer_ack_b(xfer_ack_b),
    .xfer_end_b_i(xfer_end_b_i), .xfer_end_b_o(xfer_end_b_o),
    .xfer_end_oe(xfer_end_oe), .irq_normal(irq_normal),
    .irq_error(irq_error));

  dadma_partner dadma_partner_inst (.clk(clk), .rst_b(rst_b), .cyc(cyc),
    .m_rdata(m_rdata), .m_ack(m_ack), .m_berr(m_berr),
    .xfer_request_b(xfer_request_b), .xfer_ack_b(xfer_ack_b),
    .xfer_end_b_o(xfer_end_b_o), .xfer_end_oe(xfer_end_oe),
    .xfer_end_b_i(xfer_end_b_i), .slow(slow), .err_addr(err_addr),
    .burst_req(burst_req), .pulse_en(pulse_en), .end_first(end_first),
    .ack_falls(ack_falls), .end_cnt(end_cnt));

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic rdc(input logic [31:0] a, input logic [31:0] e,
                     input string m);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(q, e, m);
  endtask : rdc

  // Loads the pointers, starts, waits for start_bit to drop
  task automatic run(input logic [31:0] md, input logic [7:0] s,
                     input logic [7:0] d, input logic [7:0] c);
    logic [31:0] q;
    int i;
    wr(`DADMA_OFF_SRC, {24'h0, s});
    wr(`DADMA_OFF_DST, {24'h0, d});
    wr(`DADMA_OFF_FC, 32'h51);
    wr(`DADMA_OFF_CNT, {24'h0, c});
    wr(`DADMA_OFF_MODE, md);
    q = 32'h1;
    for (i = 0; i < 500 && q[0] !== 1'b0; i++) begin
      ahb(1'b0, `DADMA_OFF_MODE, 32'h0, q);
    end
    chk({31'h0, q[0]}, 32'h0, "start bit cleared");
  endtask : run

  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end

  initial begin
    clk = 0; rst_b = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0;
    hsize = 3'h2; hwdata = 0; bus_grant = 0; slow = 0; burst_req = 0;
    pulse_en = 0; end_first = 0; err_addr = 8'hff; bus_clear = 0;
    mismatches = 0; n_tests = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk({31'h0, hreadyout}, 32'h1, "hreadyout");
    chk({31'h0, hresp}, 32'h0, "hresp");
    rdc(`DADMA_OFF_MODE, 32'h0, "mode reset");
    rdc(`DADMA_OFF_STAT, 32'h0, "status reset");
    rdc(32'h40, 32'h0, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      slow <= i[0];
      burst_req <= (i == 6);
      pulse_en <= (i == 7);
      af0 = ack_falls;
      ec0 = end_cnt;
      run(t_md[i], t_s[i], t_d[i], t_c[i]);
      burst_req <= 1'b0;
      pulse_en <= 1'b0;
      rdc(`DADMA_OFF_CNT, 32'h0, "count");
      rdc(`DADMA_OFF_SRC, t_s[i] + t_ss[i], "src ptr");
      rdc(`DADMA_OFF_DST, t_d[i] + t_ds[i], "dst ptr");
      for (int j = 0; j < t_c[i]; j++) begin
        chk(dadma_partner_inst.mem[t_d[i] + (t_k[i] == 2 ? 2 * j : j)],
          (t_s[i] + (t_k[i] == 1 ? 2 * j : j)) ^ 8'h5a, "data");
      end
      if (i >= 6) begin
        chk(ack_falls - af0, 8'h02, "ack count");
        chk(end_cnt - ec0, 8'h01, "end count");
      end
      rdc(`DADMA_OFF_STAT, 32'h1, "done");
      chk({31'h0, irq_normal}, 32'h1, "irq normal");
      wr(`DADMA_OFF_STAT, 32'h0);
      rdc(`DADMA_OFF_STAT, 32'h1, "write zero keeps");
      wr(`DADMA_OFF_STAT, 32'hf);
      rdc(`DADMA_OFF_STAT, 32'h0, "write one clears");
    end
    err_addr <= 8'he0;
    run(32'h5f81, 8'he0, 8'he8, 8'h04);
    rdc(`DADMA_OFF_STAT, 32'h4, "source bus error");
    chk({31'h0, irq_error}, 32'h1, "irq error");
    chk({31'h0, bus_req}, 32'h0, "bus released");
    wr(`DADMA_OFF_STAT, 32'hf);
    err_addr <= 8'hff;
    burst_req <= 1'b1;
    end_first <= 1'b1;
    run(32'h7f85, 8'h50, 8'he8, 8'h08);
    burst_req <= 1'b0;
    end_first <= 1'b0;
    rdc(`DADMA_OFF_CNT, 32'h6, "end count left");
    rdc(`DADMA_OFF_DST, 32'hea, "end dst ptr");
    rdc(`DADMA_OFF_STAT, 32'h1, "end done");
    wr(`DADMA_OFF_STAT, 32'hf);
    wr(`DADMA_OFF_CNT, 32'h40);
    wr(`DADMA_OFF_MODE, 32'h5f81);
    repeat (30) @(posedge clk);
    bus_clear <= 1'b1;
    repeat (30) @(posedge clk);
    chk({31'h0, bus_req}, 32'h0, "yield releases bus");
    rdc(`DADMA_OFF_MODE, 32'h5f81, "yield keeps start");
    bus_clear <= 1'b0;
    wr(`DADMA_OFF_MODE, 32'h5f80);
    repeat (30) @(posedge clk);
    chk({31'h0, bus_req}, 32'h0, "halt releases bus");
    ahb(1'b0, `DADMA_OFF_CNT, 32'h0, r);
    chk({31'h0, (r != 32'h0) && (r < 32'h40)}, 32'h1, "halt count");
    report_and_stop();
  end
endmodule : dadma_top_test
